// File: shared/tfbc_pkg.sv
// package: register map, field positions and reset values of the timer flag and buffer control block
package tfbc_pkg;
	// word addresses on the register bus, taken from byte address bits 5:2
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_FLAGS = 4'h1;
	localparam logic [3:0] ADDR_FLAGS_EXT = 4'h2;
	localparam logic [3:0] ADDR_PHASE_FLAGS = 4'h3;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
	localparam logic [3:0] ADDR_IO_CONTROL = 4'h5;
	localparam logic [3:0] ADDR_CONTROL = 4'h6;
	localparam logic [3:0] ADDR_GEN_A = 4'h7;
	localparam logic [3:0] ADDR_GEN_B = 4'h8;
	localparam logic [3:0] ADDR_GEN_C = 4'h9;
	localparam logic [3:0] ADDR_GEN_D = 4'hA;
	localparam logic [3:0] ADDR_PHASE_U = 4'hB;
	localparam logic [3:0] ADDR_PHASE_V = 4'hC;
	localparam logic [3:0] ADDR_PHASE_W = 4'hD;
	// timer_mode fields
	localparam int MODE_BUF_A_BIT = 4;
	localparam int MODE_BUF_B_BIT = 5;
	localparam int MODE_SEL_LSB = 0;
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_PWM1 = 4'h2;
	localparam logic [3:0] MODE_PWM2 = 4'h3;
	localparam logic [3:0] MODE_PHASE1 = 4'h4;
	localparam logic [3:0] MODE_PHASE4 = 4'h7;
	localparam logic [3:0] MODE_COMP_LO = 4'hD;
	localparam logic [3:0] MODE_COMP_HI = 4'hF;
	// timer_flags fields
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_B_BIT = 1;
	localparam int FLAG_C_BIT = 2;
	localparam int FLAG_D_BIT = 3;
	localparam int FLAG_OVF_BIT = 4;
	localparam int FLAG_UNF_BIT = 5;
	localparam logic [5:0] FLAGS_MASK = 6'h3F;
	localparam logic [1:0] EXT_MASK = 2'h3;
	localparam logic [2:0] PHASE_MASK = 3'h7;
	// io control field per phase: 2 bits at 2*phase
	localparam logic [1:0] IOC_RISING = 2'h1;
	localparam logic [1:0] IOC_FALLING = 2'h2;
	localparam logic [1:0] IOC_BOTH = 2'h3;
	localparam logic [7:0] RST_MODE = 8'hC0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_FLAGS_RD = 8'hC0;
endpackage : tfbc_pkg

// File: src/tfbc_timer_flag_buffer_ctrl.sv
// timer flag and buffer control: status flags, pulse measurement flags and buffer pairing
`timescale 1ns/100ps
module tfbc_timer_flag_buffer_ctrl #(
	parameter int DATA_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [DATA_W-1:0] i_counter,
	input wire logic i_underflow,
	input wire logic i_overflow,
	input wire logic i_match_a,
	input wire logic i_match_b,
	input wire logic i_match_c,
	input wire logic i_match_d,
	input wire logic i_match_e,
	input wire logic i_match_f,
	input wire logic i_dma_start_a,
	input wire logic [2:0] i_phase_edge_rise,
	input wire logic [2:0] i_phase_edge_fall,
	input wire logic [3*DATA_W-1:0] i_phase_counter,
	output logic o_irq,
	output logic o_match_irq_a,
	output logic [3:0] o_gen_event,
	output logic o_comp_pwm,
	output logic o_io_write_refused
);
	logic [7:0] timer_mode_reg;
	logic [5:0] timer_flags_reg;
	logic [1:0] timer_flags_ext_reg;
	logic [2:0] three_phase_flags_reg;
	logic [7:0] irq_enable_reg;
	logic [5:0] io_control_reg;
	logic [7:0] control_reg;
	logic [5:0] seen_flags_reg;
	logic [1:0] seen_ext_reg;
	logic [2:0] seen_phase_reg;
	logic [DATA_W-1:0] general_reg_a, general_reg_b, general_reg_c, general_reg_d;
	logic [DATA_W-1:0] phase_reg [3];
	logic ack_reg;
	logic wr, rd, be0;
	logic [3:0] word;
	logic buffer_pair_a, buffer_pair_b, comp_pwm, plain_mode, in_tb;
	logic [3:0] mode_sel;
	logic [5:0] flag_set;
	logic [2:0] phase_copy;

	// returns bits to clear: written zero where a one was read earlier
	function automatic logic [5:0] tfbc_clr(input logic [5:0] wdata, input logic [5:0] seen);
		return ~wdata & seen;
	endfunction : tfbc_clr

	// one wait state keeps read data aligned with the registered answer
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
	assign word = i_avs_address[5:2];
	assign be0 = i_avs_byteenable[0];
	assign wr = i_avs_write & ack_reg & be0 & (i_avs_address[1:0] == 2'h0);
	// a read counts as seen when readdata is captured, so a flag set in the wait state is not clearable yet
	assign rd = i_avs_read & ~ack_reg;
	assign mode_sel = timer_mode_reg[tfbc_pkg::MODE_SEL_LSB +: 4];
	assign buffer_pair_a = timer_mode_reg[tfbc_pkg::MODE_BUF_A_BIT];
	assign buffer_pair_b = timer_mode_reg[tfbc_pkg::MODE_BUF_B_BIT];
	assign comp_pwm = (mode_sel >= tfbc_pkg::MODE_COMP_LO) && (mode_sel <= tfbc_pkg::MODE_COMP_HI);
	assign plain_mode = (mode_sel == tfbc_pkg::MODE_NORMAL) || (mode_sel == tfbc_pkg::MODE_PWM1) ||
		(mode_sel == tfbc_pkg::MODE_PWM2) ||
		((mode_sel >= tfbc_pkg::MODE_PHASE1) && (mode_sel <= tfbc_pkg::MODE_PHASE4));
	// control bit 0 marks the tb interval, driven by software from the pwm sequencer
	assign in_tb = control_reg[0];
	assign o_comp_pwm = comp_pwm;

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
		end
	end

	// event gating for the buffered general registers
	always_comb begin
		flag_set = '0;
		flag_set[tfbc_pkg::FLAG_A_BIT] = i_match_a;
		flag_set[tfbc_pkg::FLAG_B_BIT] = i_match_b;
		flag_set[tfbc_pkg::FLAG_C_BIT] = i_match_c & (~buffer_pair_a | comp_pwm);
		flag_set[tfbc_pkg::FLAG_D_BIT] = i_match_d & (~buffer_pair_b | comp_pwm);
		// tb interval matches still set c and d; the enable bits are left to software
		if (comp_pwm && in_tb) begin
			flag_set[tfbc_pkg::FLAG_C_BIT] = i_match_c;
			flag_set[tfbc_pkg::FLAG_D_BIT] = i_match_d;
		end
		flag_set[tfbc_pkg::FLAG_OVF_BIT] = i_overflow;
		flag_set[tfbc_pkg::FLAG_UNF_BIT] = i_underflow;
	end

	// copy moment per phase from its io control field
	always_comb begin
		phase_copy = '0;
		for (int p = 0; p < 3; p++) begin
			unique case (io_control_reg[2*p +: 2])
				tfbc_pkg::IOC_RISING: phase_copy[p] = i_phase_edge_rise[p];
				tfbc_pkg::IOC_FALLING: phase_copy[p] = i_phase_edge_fall[p];
				tfbc_pkg::IOC_BOTH: phase_copy[p] = i_phase_edge_rise[p] | i_phase_edge_fall[p];
				default: phase_copy[p] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			timer_mode_reg <= tfbc_pkg::RST_MODE;
			irq_enable_reg <= tfbc_pkg::RST_BYTE;
			io_control_reg <= '0;
			control_reg <= tfbc_pkg::RST_BYTE;
			o_io_write_refused <= 1'b0;
		end else if (wr) begin
			unique case (word)
				tfbc_pkg::ADDR_MODE: timer_mode_reg <= i_avs_writedata[7:0];
				tfbc_pkg::ADDR_IRQ_ENABLE: irq_enable_reg <= i_avs_writedata[7:0];
				tfbc_pkg::ADDR_CONTROL: control_reg <= i_avs_writedata[7:0];
				tfbc_pkg::ADDR_IO_CONTROL: begin
					// ignored outside plain modes to protect capture setup
					if (plain_mode) begin
						io_control_reg <= i_avs_writedata[5:0];
					end
					o_io_write_refused <= ~plain_mode;
				end
				default: ;
			endcase
		end
	end

	// status flags: set wins over clear, a written one keeps the flag
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			timer_flags_reg <= '0;
			seen_flags_reg <= '0;
		end else begin
			logic [5:0] clr;
			clr = '0;
			if (wr && word == tfbc_pkg::ADDR_FLAGS) begin
				clr = tfbc_clr(i_avs_writedata[5:0], seen_flags_reg) & tfbc_pkg::FLAGS_MASK;
			end
			if (i_dma_start_a) begin
				clr[tfbc_pkg::FLAG_A_BIT] = 1'b1;
			end
			timer_flags_reg <= (timer_flags_reg & ~clr) | flag_set;
			if (rd && word == tfbc_pkg::ADDR_FLAGS) begin
				seen_flags_reg <= timer_flags_reg;
			end else begin
				seen_flags_reg <= seen_flags_reg & ~clr & timer_flags_reg;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			timer_flags_ext_reg <= '0;
			seen_ext_reg <= '0;
		end else begin
			logic [1:0] clr;
			clr = '0;
			if (wr && word == tfbc_pkg::ADDR_FLAGS_EXT) begin
				clr = ~i_avs_writedata[1:0] & seen_ext_reg & tfbc_pkg::EXT_MASK;
			end
			timer_flags_ext_reg <= (timer_flags_ext_reg & ~clr) | {i_match_f, i_match_e};
			if (rd && word == tfbc_pkg::ADDR_FLAGS_EXT) begin
				seen_ext_reg <= timer_flags_ext_reg;
			end else begin
				seen_ext_reg <= seen_ext_reg & ~clr & timer_flags_ext_reg;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			three_phase_flags_reg <= '0;
			seen_phase_reg <= '0;
			for (int p = 0; p < 3; p++) begin
				phase_reg[p] <= '0;
			end
		end else begin
			logic [2:0] clr;
			clr = '0;
			if (wr && word == tfbc_pkg::ADDR_PHASE_FLAGS) begin
				clr = ~i_avs_writedata[2:0] & seen_phase_reg & tfbc_pkg::PHASE_MASK;
			end
			three_phase_flags_reg <= (three_phase_flags_reg & ~clr) | phase_copy;
			for (int p = 0; p < 3; p++) begin
				if (phase_copy[p]) begin
					phase_reg[p] <= i_phase_counter[p*DATA_W +: DATA_W];
				end
			end
			if (rd && word == tfbc_pkg::ADDR_PHASE_FLAGS) begin
				seen_phase_reg <= three_phase_flags_reg;
			end else begin
				seen_phase_reg <= seen_phase_reg & ~clr & three_phase_flags_reg;
			end
		end
	end

	// general registers: on a match the buffer value moves into its partner
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			general_reg_a <= '0;
			general_reg_b <= '0;
			general_reg_c <= '0;
			general_reg_d <= '0;
		end else begin
			if (wr && word == tfbc_pkg::ADDR_GEN_C) begin
				general_reg_c <= i_avs_writedata[DATA_W-1:0];
			end
			if (wr && word == tfbc_pkg::ADDR_GEN_D) begin
				general_reg_d <= i_avs_writedata[DATA_W-1:0];
			end
			if (wr && word == tfbc_pkg::ADDR_GEN_A) begin
				general_reg_a <= i_avs_writedata[DATA_W-1:0];
			end else if (buffer_pair_a && i_match_a) begin
				general_reg_a <= general_reg_c;
			end
			if (wr && word == tfbc_pkg::ADDR_GEN_B) begin
				general_reg_b <= i_avs_writedata[DATA_W-1:0];
			end else if (buffer_pair_b && i_match_b) begin
				general_reg_b <= general_reg_d;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_gen_event <= '0;
			o_match_irq_a <= 1'b0;
		end else begin
			o_gen_event <= flag_set[3:0];
			o_match_irq_a <= timer_flags_reg[tfbc_pkg::FLAG_A_BIT] & irq_enable_reg[tfbc_pkg::FLAG_A_BIT];
		end
	end

	// phase w has no enable bit in the 8-bit enable register
	assign o_irq = |(({three_phase_flags_reg[1:0], timer_flags_reg} & irq_enable_reg) |
		({6'h00, timer_flags_ext_reg} & {6'h00, control_reg[2:1]}));

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read & ~ack_reg) begin
			o_avs_readdata <= '0;
			unique case (word)
				tfbc_pkg::ADDR_MODE: o_avs_readdata[7:0] <= timer_mode_reg;
				tfbc_pkg::ADDR_FLAGS: o_avs_readdata[7:0] <= tfbc_pkg::RST_FLAGS_RD | {2'h0, timer_flags_reg};
				tfbc_pkg::ADDR_FLAGS_EXT: o_avs_readdata[1:0] <= timer_flags_ext_reg;
				tfbc_pkg::ADDR_PHASE_FLAGS: o_avs_readdata[2:0] <= three_phase_flags_reg;
				tfbc_pkg::ADDR_IRQ_ENABLE: o_avs_readdata[7:0] <= irq_enable_reg;
				tfbc_pkg::ADDR_IO_CONTROL: o_avs_readdata[5:0] <= io_control_reg;
				tfbc_pkg::ADDR_CONTROL: o_avs_readdata[7:0] <= control_reg;
				tfbc_pkg::ADDR_GEN_A: o_avs_readdata[DATA_W-1:0] <= general_reg_a;
				tfbc_pkg::ADDR_GEN_B: o_avs_readdata[DATA_W-1:0] <= general_reg_b;
				tfbc_pkg::ADDR_GEN_C: o_avs_readdata[DATA_W-1:0] <= general_reg_c;
				tfbc_pkg::ADDR_GEN_D: o_avs_readdata[DATA_W-1:0] <= general_reg_d;
				tfbc_pkg::ADDR_PHASE_U: o_avs_readdata[DATA_W-1:0] <= phase_reg[0];
				tfbc_pkg::ADDR_PHASE_V: o_avs_readdata[DATA_W-1:0] <= phase_reg[1];
				tfbc_pkg::ADDR_PHASE_W: o_avs_readdata[DATA_W-1:0] <= phase_reg[2];
				default: o_avs_readdata <= '0;
			endcase
		end
	end

	wire logic unused_ok = &{1'b0, i_counter, i_avs_byteenable[3:1]};

	dma_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		i_dma_start_a && !i_match_a |=> !timer_flags_reg[tfbc_pkg::FLAG_A_BIT]) else $error("dma start left flag a");
	one_keeps_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		wr && word == tfbc_pkg::ADDR_FLAGS && (&i_avs_writedata[5:0]) && !i_dma_start_a
		|=> timer_flags_reg == ($past(timer_flags_reg) | $past(flag_set))) else $error("written one changed a flag");
	unread_clr_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		wr && word == tfbc_pkg::ADDR_FLAGS && seen_flags_reg == 6'h00 && !i_dma_start_a
		|=> timer_flags_reg == ($past(timer_flags_reg) | $past(flag_set))) else $error("unread flag cleared");
	ext_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		wr && word == tfbc_pkg::ADDR_FLAGS_EXT && seen_ext_reg[0] && !i_avs_writedata[0] && !i_match_e
		|=> !timer_flags_ext_reg[0]) else $error("flag e not cleared");
	phase_set_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		phase_copy[0] |=> three_phase_flags_reg[0] && phase_reg[0] == $past(i_phase_counter[DATA_W-1:0]))
		else $error("phase u copy missed");
	ioc_rise_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		io_control_reg[1:0] == tfbc_pkg::IOC_RISING && i_phase_edge_rise[0] |-> phase_copy[0])
		else $error("rising edge copy missed");
	buf_b_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		buffer_pair_b && i_match_b && !(wr && word == tfbc_pkg::ADDR_GEN_B)
		|=> general_reg_b == $past(general_reg_d)) else $error("b not loaded from d");
	buf_d_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		buffer_pair_b && !comp_pwm |-> !flag_set[tfbc_pkg::FLAG_D_BIT]) else $error("buffered d made event");
	tb_match_d_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		comp_pwm && in_tb && i_match_d |=> timer_flags_reg[tfbc_pkg::FLAG_D_BIT]) else $error("tb d match lost");
	buf_c_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		buffer_pair_a && !comp_pwm |-> !flag_set[tfbc_pkg::FLAG_C_BIT]) else $error("buffered c made event");
	tb_match_c_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		comp_pwm && in_tb && i_match_c |=> timer_flags_reg[tfbc_pkg::FLAG_C_BIT]) else $error("tb c match lost");
	ioc_guard_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		wr && word == tfbc_pkg::ADDR_IO_CONTROL && !plain_mode |=> $stable(io_control_reg))
		else $error("io control changed in wrong mode");
	bus_answer_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("bus answer late");

	flag_clear_c: cover property (@(posedge i_ref_clk) disable iff (i_srst)
		rd && word == tfbc_pkg::ADDR_FLAGS ##[1:8] wr && word == tfbc_pkg::ADDR_FLAGS);
	dma_clear_c: cover property (@(posedge i_ref_clk) disable iff (i_srst)
		timer_flags_reg[0] && i_dma_start_a);
	phase_copy_c: cover property (@(posedge i_ref_clk) disable iff (i_srst) |phase_copy);
	buffer_load_c: cover property (@(posedge i_ref_clk) disable iff (i_srst) buffer_pair_b && i_match_b);
endmodule : tfbc_timer_flag_buffer_ctrl

// File: testbench/tfbc_timer_flag_buffer_ctrl_tb.sv
// self-checking testbench for the timer flag and buffer control block
`timescale 1ns/100ps
module tfbc_timer_flag_buffer_ctrl_tb;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [5:0] adr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h00000000;
	logic [8:0] ev = 9'h000;
	logic [2:0] rise = 3'h0;
	logic [2:0] fall = 3'h0;
	logic [47:0] pcnt = 48'h000000000000;
	logic [31:0] rdata;
	logic wait_r;
	logic irq;
	logic irq_a;
	logic cpwm;
	logic refused;
	logic [3:0] gev;
	logic [3:0] gev_seen = 4'h0;
	int err_count = 0;
	int comparisons = 0;
	logic [31:0] exp_q[$];
	logic [31:0] e;
	logic [5:0] m;
	logic [5:0] k;

	always #12.5 i_ref_clk = ~i_ref_clk;

	// event vector: bits 0..5 follow the flag layout, 6 and 7 are e and f, 8 starts dma on a
	tfbc_timer_flag_buffer_ctrl i_tfbc_timer_flag_buffer_ctrl (
		.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
		.i_counter(16'h0000), .i_underflow(ev[5]), .i_overflow(ev[4]), .i_match_a(ev[0]), .i_match_b(ev[1]),
		.i_match_c(ev[2]), .i_match_d(ev[3]), .i_match_e(ev[6]), .i_match_f(ev[7]), .i_dma_start_a(ev[8]),
		.i_phase_edge_rise(rise), .i_phase_edge_fall(fall), .i_phase_counter(pcnt), .o_irq(irq),
		.o_match_irq_a(irq_a), .o_gen_event(gev), .o_comp_pwm(cpwm), .o_io_write_refused(refused)
	);

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	// entered just after a rising edge; one idle edge follows so strobes never toggle twice in one step
	task automatic bus(input logic w, input logic [3:0] word, input logic [31:0] d);
		adr <= {word, 2'b00};
		wd <= d;
		rd <= ~w;
		wr <= w;
		do @(posedge i_ref_clk); while (wait_r !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_ref_clk);
	endtask : bus

	task automatic rdreg(input logic [3:0] word, input logic [31:0] ex);
		exp_q.push_back(ex);
		bus(1'b0, word, 32'h00000000);
	endtask : rdreg

	task automatic pulse(input logic [8:0] v, input logic [2:0] r, input logic [2:0] f);
		ev <= v;
		rise <= r;
		fall <= f;
		@(posedge i_ref_clk);
		ev <= 9'h000;
		rise <= 3'h0;
		fall <= 3'h0;
		@(posedge i_ref_clk);
		// registered event from the pulse still stands at this edge
		gev_seen = gev;
	endtask : pulse

	// outputs are sampled at the next edge, where the last updates have settled
	task automatic ochk(input string nm, input logic ex);
		logic got;
		@(posedge i_ref_clk);
		case (nm)
			"irq": got = irq;
			"match_irq_a": got = irq_a;
			"comp_pwm": got = cpwm;
			default: got = refused;
		endcase
		chk(nm, {31'h0, ex}, {31'h0, got});
	endtask : ochk

	// read data are taken at the edge where waitrequest is seen low
	always @(posedge i_ref_clk) begin
		if (rd === 1'b1 && wait_r === 1'b0) begin
			e = exp_q.pop_front();
			chk("readdata", e, rdata);
		end
	end

	initial begin
		repeat (20000) @(posedge i_ref_clk);
		err_count++;
		$display("ERROR watchdog expected done seen hang");
		complete_run();
	end

	initial begin
		void'($urandom(50));
		repeat (6) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		@(posedge i_ref_clk);
		rdreg(tfbc_pkg::ADDR_MODE, 32'h000000C0);
		rdreg(tfbc_pkg::ADDR_FLAGS, 32'h000000C0);
		rdreg(tfbc_pkg::ADDR_FLAGS_EXT, 32'h00000000);
		rdreg(tfbc_pkg::ADDR_PHASE_FLAGS, 32'h00000000);
		rdreg(4'hE, 32'h00000000);
		ochk("irq", 1'b0);
		$display("test reset done");
		repeat (4) begin
			m = 6'($urandom_range(63));
			k = 6'($urandom_range(63));
			pulse({3'h0, m}, 3'h0, 3'h0);
			chk("gen_event", {28'h0, m[3:0]}, {28'h0, gev_seen});
			rdreg(tfbc_pkg::ADDR_FLAGS, {24'h0, 2'b11, m});
			bus(1'b1, tfbc_pkg::ADDR_FLAGS, {26'h0, ~k});
			rdreg(tfbc_pkg::ADDR_FLAGS, {24'h0, 2'b11, m & ~k});
			bus(1'b1, tfbc_pkg::ADDR_FLAGS, 32'h00000000);
			rdreg(tfbc_pkg::ADDR_FLAGS, 32'h000000C0);
		end
		// a flag set after the last read survives a zero write
		pulse(9'h001, 3'h0, 3'h0);
		bus(1'b1, tfbc_pkg::ADDR_FLAGS, 32'h00000000);
		rdreg(tfbc_pkg::ADDR_FLAGS, 32'h000000C1);
		$display("test flag clearing done");
		bus(1'b1, tfbc_pkg::ADDR_IRQ_ENABLE, 32'h00000001);
		ochk("match_irq_a", 1'b1);
		ochk("irq", 1'b1);
		pulse(9'h100, 3'h0, 3'h0);
		ochk("match_irq_a", 1'b0);
		rdreg(tfbc_pkg::ADDR_FLAGS, 32'h000000C0);
		bus(1'b1, tfbc_pkg::ADDR_IRQ_ENABLE, 32'h00000000);
		pulse(9'h002, 3'h0, 3'h0);
		ochk("irq", 1'b0);
		bus(1'b1, tfbc_pkg::ADDR_IRQ_ENABLE, 32'h00000002);
		ochk("irq", 1'b1);
		rdreg(tfbc_pkg::ADDR_FLAGS, 32'h000000C2);
		bus(1'b1, tfbc_pkg::ADDR_FLAGS, 32'h0000003D);
		ochk("irq", 1'b0);
		$display("test dma and interrupt done");
		pulse(9'h0C0, 3'h0, 3'h0);
		rdreg(tfbc_pkg::ADDR_FLAGS_EXT, 32'h00000003);
		bus(1'b1, tfbc_pkg::ADDR_FLAGS_EXT, 32'h00000002);
		rdreg(tfbc_pkg::ADDR_FLAGS_EXT, 32'h00000002);
		bus(1'b1, tfbc_pkg::ADDR_FLAGS_EXT, 32'h00000000);
		rdreg(tfbc_pkg::ADDR_FLAGS_EXT, 32'h00000000);
		$display("test extra flags done");
		bus(1'b1, tfbc_pkg::ADDR_IO_CONTROL, {26'h0, tfbc_pkg::IOC_BOTH, tfbc_pkg::IOC_FALLING, tfbc_pkg::IOC_RISING});
		pcnt <= {16'($urandom), 16'($urandom), 16'($urandom)};
		pulse(9'h000, 3'h7, 3'h0);
		rdreg(tfbc_pkg::ADDR_PHASE_FLAGS, 32'h00000005);
		rdreg(tfbc_pkg::ADDR_PHASE_U, {16'h0, pcnt[15:0]});
		rdreg(tfbc_pkg::ADDR_PHASE_W, {16'h0, pcnt[47:32]});
		bus(1'b1, tfbc_pkg::ADDR_PHASE_FLAGS, 32'h00000000);
		pulse(9'h000, 3'h0, 3'h7);
		rdreg(tfbc_pkg::ADDR_PHASE_FLAGS, 32'h00000006);
		bus(1'b1, tfbc_pkg::ADDR_PHASE_FLAGS, 32'h00000000);
		bus(1'b1, tfbc_pkg::ADDR_IO_CONTROL, 32'h00000000);
		pulse(9'h000, 3'h7, 3'h7);
		rdreg(tfbc_pkg::ADDR_PHASE_FLAGS, 32'h00000000);
		$display("test phase measure done");
		bus(1'b1, tfbc_pkg::ADDR_MODE, 32'h00000030);
		pulse(9'h00C, 3'h0, 3'h0);
		rdreg(tfbc_pkg::ADDR_FLAGS, 32'h000000C0);
		chk("gen_event", 32'h00000000, {28'h0, gev_seen});
		bus(1'b1, tfbc_pkg::ADDR_MODE, 32'h0000003D);
		bus(1'b1, tfbc_pkg::ADDR_CONTROL, 32'h00000001);
		ochk("comp_pwm", 1'b1);
		pulse(9'h00C, 3'h0, 3'h0);
		rdreg(tfbc_pkg::ADDR_FLAGS, 32'h000000CC);
		chk("gen_event", 32'h0000000C, {28'h0, gev_seen});
		bus(1'b1, tfbc_pkg::ADDR_FLAGS, 32'h00000000);
		bus(1'b1, tfbc_pkg::ADDR_IO_CONTROL, 32'h00000015);
		ochk("io_refused", 1'b1);
		rdreg(tfbc_pkg::ADDR_IO_CONTROL, 32'h00000000);
		bus(1'b1, tfbc_pkg::ADDR_MODE, 32'h00000000);
		ochk("comp_pwm", 1'b0);
		bus(1'b1, tfbc_pkg::ADDR_IO_CONTROL, 32'h00000001);
		ochk("io_refused", 1'b0);
		rdreg(tfbc_pkg::ADDR_IO_CONTROL, 32'h00000001);
		$display("test buffer and mode done");
		repeat (2) @(posedge i_ref_clk);
		complete_run();
	end
endmodule : tfbc_timer_flag_buffer_ctrl_tb
